// ==== rtl/tw_waveform_control.sv ====
// 8-bit timer waveform generator with its control registers on APB.
// Assumes TIMER_TICK and DIR_x come from logic on CLK_SYS; pins are resolved outside.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// [RULE_01] Nonzero A output mode overrides port pin; the code leaves A mode 01 unconnected in PWM modes while the high bit is clear
// [RULE_02] Pin driver only when direction is output
// [RULE_03] Non-PWM A: off, toggle, clear, set on match
// [RULE_04] Fast PWM A: match action, opposite at bottom
// [RULE_05] PWM A mode 01 toggles only with high bit
// [RULE_06] Phase correct A: up/down matches act oppositely
// [RULE_07] Fast A compare at top: bottom action only
// [RULE_08] Phase correct A compare at top: act at top
// [RULE_09] Nonzero B output mode overrides port pin; the code leaves B mode 01 unconnected in fast and phase correct modes
// [RULE_10] Non-PWM B: off, toggle, clear, set on match
// [RULE_11] Fast PWM B: 01 reserved, match/bottom actions
// [RULE_12] Phase correct B: 01 reserved, up/down actions
// [RULE_13] B compare at top: match ignored, act at top
// [RULE_14] Control bits 3 and 2 read zero
// [RULE_15] Mode from low bits plus high bit
// [RULE_16] Top is max or compare A by mode
// [RULE_17] Compare update immediate, top or bottom by mode
// [RULE_18] Overflow flag at max, bottom or top
// [RULE_19] Software never selects modes 4 or 6
// [RULE_20] Fast PWM counts to top then zero
// [RULE_21] Phase correct reverses at top, holds once
// [RULE_22] Bottom means counter value zero
module tw_waveform_control (
  input  wire logic               CLK_SYS,
  input  wire logic               ARST_N,
  input  wire logic [11:0]        PADDR,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [31:0]        PWDATA,
  input  wire logic [3:0]         PSTRB,
  output logic                    PREADY,
  output logic [31:0]             PRDATA,
  output logic                    PSLVERR,
  input  wire logic               TIMER_TICK,
  input  wire logic               DIR_A,
  input  wire logic               DIR_B,
  output tw_pkg::tw_pin_type      CHAN_A_PIN,
  output tw_pkg::tw_pin_type      CHAN_B_PIN,
  output logic [7:0]              COUNTER_VALUE,
  output logic                    COUNT_DOWN,
  output logic                    OVERFLOW_FLAG
);

  logic [7:0]              timer_waveform_control;
  logic                    wave_mode_high_bit;
  logic [7:0]              cmp_buf [2];
  logic [7:0]              cmp_act [2];
  logic [7:0]              counter_value;
  logic                    count_down;
  logic                    overflow_flag;
  logic                    block_match;
  logic [1:0]              oc;
  logic [1:0]              next_oc;
  logic [1:0]              match;
  logic [1:0]              connected;
  logic [1:0]              dir_in;
  tw_pkg::tw_pin_type      pin_vec [2];
  tw_pkg::tw_mode_type     wave_mode_select;
  logic                    is_fast;
  logic                    is_pc;
  logic                    top_from_a;
  logic [7:0]              top;
  logic                    at_top;
  logic                    wrap_evt;
  logic                    top_evt_pc;
  logic                    bottom_pc;
  logic                    ovf_set;
  logic                    update_evt;
  logic [7:0]              next_count;
  logic                    next_down;
  logic                    setup;
  logic                    access;
  logic                    wr;
  logic                    rd_hit;
  logic [31:0]             rd_val;
  logic                    wr_wave;
  logic                    wr_mode;
  logic                    wr_cmp_a;
  logic                    wr_cmp_b;
  logic                    wr_count;
  logic                    wr_status;

  // Three-bit mode and its derived attributes
  assign wave_mode_select = tw_pkg::tw_mode_type'({wave_mode_high_bit, timer_waveform_control[1:0]}); // [RULE_15]
  assign is_fast    = (wave_mode_select == tw_pkg::TW_MODE_FAST_FF) || (wave_mode_select == tw_pkg::TW_MODE_FAST_CMP);
  assign is_pc      = (wave_mode_select == tw_pkg::TW_MODE_PC_FF) || (wave_mode_select == tw_pkg::TW_MODE_PC_CMP);
  assign top_from_a = (wave_mode_select == tw_pkg::TW_MODE_CLR_MATCH) || (wave_mode_select == tw_pkg::TW_MODE_PC_CMP)
                   || (wave_mode_select == tw_pkg::TW_MODE_FAST_CMP);
  assign top        = top_from_a ? cmp_act[0] : tw_pkg::TW_MAX; // [RULE_16]
  assign at_top     = (counter_value == top);

  // Sequence events; bottom is a zero count
  assign wrap_evt   = TIMER_TICK && at_top && (is_fast || (wave_mode_select == tw_pkg::TW_MODE_CLR_MATCH)); // [RULE_22]
  assign top_evt_pc = TIMER_TICK && is_pc && at_top && !count_down;
  assign bottom_pc  = TIMER_TICK && is_pc && count_down && (counter_value == tw_pkg::TW_BOTTOM); // [RULE_22]

  // Overflow event per mode
  always_comb begin
    unique case (wave_mode_select)
      tw_pkg::TW_MODE_NORMAL,
      tw_pkg::TW_MODE_CLR_MATCH,
      tw_pkg::TW_MODE_FAST_FF:  ovf_set = TIMER_TICK && (counter_value == tw_pkg::TW_MAX); // [RULE_18]
      tw_pkg::TW_MODE_PC_FF,
      tw_pkg::TW_MODE_PC_CMP:   ovf_set = bottom_pc; // [RULE_18]
      tw_pkg::TW_MODE_FAST_CMP: ovf_set = TIMER_TICK && at_top; // [RULE_18]
      tw_pkg::TW_MODE_RSV4,
      tw_pkg::TW_MODE_RSV6:     ovf_set = 1'b0;
    endcase
  end

  // Compare double-buffer transfer point per mode
  always_comb begin
    unique case (wave_mode_select)
      tw_pkg::TW_MODE_PC_FF,
      tw_pkg::TW_MODE_PC_CMP:   update_evt = top_evt_pc; // [RULE_17]
      tw_pkg::TW_MODE_FAST_FF,
      tw_pkg::TW_MODE_FAST_CMP: update_evt = wrap_evt; // [RULE_17] [RULE_22]
      tw_pkg::TW_MODE_NORMAL,
      tw_pkg::TW_MODE_CLR_MATCH,
      tw_pkg::TW_MODE_RSV4,
      tw_pkg::TW_MODE_RSV6:     update_evt = 1'b1; // [RULE_17]
    endcase
  end

  // Next count and direction
  always_comb begin
    next_count = counter_value;
    next_down  = 1'b0;
    if (is_pc) begin
      next_down = count_down;
      if (!count_down) begin
        if (at_top) begin
          next_down  = 1'b1; // [RULE_21]
          next_count = (top == tw_pkg::TW_BOTTOM) ? tw_pkg::TW_BOTTOM : 8'(counter_value - 8'h01);
        end else begin
          next_count = 8'(counter_value + 8'h01);
        end
      end else if (counter_value == tw_pkg::TW_BOTTOM) begin
        next_down  = 1'b0;
        next_count = (top == tw_pkg::TW_BOTTOM) ? tw_pkg::TW_BOTTOM : 8'h01;
      end else begin
        next_count = 8'(counter_value - 8'h01);
      end
    end else if (wrap_evt) begin
      next_count = tw_pkg::TW_BOTTOM; // [RULE_20]
    end else begin
      next_count = 8'(counter_value + 8'h01);
    end
  end

  // APB phases and decode
  assign setup     = PSEL && !PENABLE;
  assign access    = PSEL && PENABLE;
  assign PREADY    = access;
  assign wr        = access && PWRITE && PSTRB[0] && !PSLVERR;
  assign wr_wave   = wr && (PADDR == tw_pkg::TW_ADDR_WAVE_CTRL);
  assign wr_mode   = wr && (PADDR == tw_pkg::TW_ADDR_MODE_CTRL);
  assign wr_cmp_a  = wr && (PADDR == tw_pkg::TW_ADDR_CMP_A);
  assign wr_cmp_b  = wr && (PADDR == tw_pkg::TW_ADDR_CMP_B);
  assign wr_count  = wr && (PADDR == tw_pkg::TW_ADDR_COUNT);
  assign wr_status = wr && (PADDR == tw_pkg::TW_ADDR_STATUS);

  // Read mux, unmapped addresses flagged
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (PADDR)
      tw_pkg::TW_ADDR_WAVE_CTRL: rd_val[7:0] = timer_waveform_control & tw_pkg::TW_WAVE_CTRL_WMASK; // [RULE_14]
      tw_pkg::TW_ADDR_MODE_CTRL: rd_val[tw_pkg::TW_MODE_HIGH_POS] = wave_mode_high_bit;
      tw_pkg::TW_ADDR_CMP_A:     rd_val[7:0] = cmp_buf[0];
      tw_pkg::TW_ADDR_CMP_B:     rd_val[7:0] = cmp_buf[1];
      tw_pkg::TW_ADDR_COUNT:     rd_val[7:0] = counter_value;
      tw_pkg::TW_ADDR_STATUS: begin
        rd_val[tw_pkg::TW_OVF_POS] = overflow_flag;
        rd_val[tw_pkg::TW_DIR_POS] = count_down;
      end
      default:                   rd_hit = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_val;
      PSLVERR <= !rd_hit;
    end
  end

  // Control registers
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      timer_waveform_control <= tw_pkg::TW_RESET_BYTE;
      wave_mode_high_bit     <= 1'b0;
    end else begin
      if (wr_wave) begin
        timer_waveform_control <= PWDATA[7:0] & tw_pkg::TW_WAVE_CTRL_WMASK; // [RULE_14]
      end
      if (wr_mode) begin
        wave_mode_high_bit <= PWDATA[tw_pkg::TW_MODE_HIGH_POS]; // [RULE_15]
      end
    end
  end

  // Compare buffers and active compare values
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_buf[0] <= tw_pkg::TW_RESET_BYTE;
      cmp_buf[1] <= tw_pkg::TW_RESET_BYTE;
      cmp_act[0] <= tw_pkg::TW_RESET_BYTE;
      cmp_act[1] <= tw_pkg::TW_RESET_BYTE;
    end else begin
      if (wr_cmp_a) begin
        cmp_buf[0] <= PWDATA[7:0];
      end
      if (wr_cmp_b) begin
        cmp_buf[1] <= PWDATA[7:0];
      end
      if (update_evt) begin
        cmp_act[0] <= cmp_buf[0]; // [RULE_17]
        cmp_act[1] <= cmp_buf[1];
      end
    end
  end

  // Counter, direction and match blocking after a counter write
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      counter_value <= tw_pkg::TW_RESET_BYTE;
      count_down    <= 1'b0;
      block_match   <= 1'b0;
    end else if (wr_count) begin
      counter_value <= PWDATA[7:0];
      block_match   <= 1'b1;
    end else begin
      if (TIMER_TICK) begin
        counter_value <= next_count;
        count_down    <= next_down;
        block_match   <= 1'b0;
      end
      if (!is_pc) begin
        count_down <= 1'b0;
      end
    end
  end

  // Overflow flag, write one clears, set wins
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= ovf_set || (overflow_flag && !(wr_status && PWDATA[tw_pkg::TW_OVF_POS])); // [RULE_18]
    end
  end

  assign dir_in = {DIR_B, DIR_A};

  // Per-channel compare output logic
  for (genvar i = 0; i < 2; i++) begin : g_chan
    localparam int LSB = (i == 0) ? tw_pkg::TW_CHA_MODE_LSB : tw_pkg::TW_CHB_MODE_LSB;
    tw_pkg::tw_out_mode_type com;
    logic                    cmp_is_top;
    logic                    toggle_ok;

    assign com        = tw_pkg::tw_out_mode_type'(timer_waveform_control[LSB+1:LSB]);
    assign cmp_is_top = (cmp_act[i] == top);
    assign toggle_ok  = (i == 0) && wave_mode_high_bit; // [RULE_05] [RULE_11] [RULE_12]
    assign match[i]   = TIMER_TICK && !block_match && (counter_value == cmp_act[i]);

    // Pin connection and driver enable
    assign connected[i] = (com != tw_pkg::TW_OUT_OFF)
                       && !((is_fast || is_pc) && (com == tw_pkg::TW_OUT_TOGGLE) && !toggle_ok); // [RULE_01] [RULE_09] [RULE_05]
    assign pin_vec[i].out      = oc[i];
    assign pin_vec[i].override = connected[i];
    assign pin_vec[i].oe       = connected[i] && dir_in[i]; // [RULE_02]

    // Next output level
    always_comb begin
      next_oc[i] = oc[i];
      if (!is_fast && !is_pc) begin
        if (match[i]) begin
          unique case (com)
            tw_pkg::TW_OUT_OFF:    next_oc[i] = oc[i]; // [RULE_03] [RULE_10]
            tw_pkg::TW_OUT_TOGGLE: next_oc[i] = !oc[i];
            tw_pkg::TW_OUT_CLEAR:  next_oc[i] = 1'b0;
            tw_pkg::TW_OUT_SET:    next_oc[i] = 1'b1;
          endcase
        end
      end else if (com == tw_pkg::TW_OUT_TOGGLE) begin
        if (toggle_ok && match[i]) begin
          next_oc[i] = !oc[i]; // [RULE_05]
        end
      end else if (com[1]) begin
        if (is_fast) begin
          if (wrap_evt) begin
            next_oc[i] = !com[0]; // [RULE_04] [RULE_11] [RULE_07] [RULE_13]
          end else if (match[i] && !cmp_is_top) begin
            next_oc[i] = com[0]; // [RULE_04] [RULE_11]
          end
        end else if (cmp_is_top) begin
          if (top_evt_pc) begin
            next_oc[i] = !com[0]; // [RULE_08] [RULE_13]
          end
        end else if (match[i]) begin
          next_oc[i] = count_down ? !com[0] : com[0]; // [RULE_06] [RULE_12]
        end
      end
    end

    // Output register
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
        oc[i] <= 1'b0;
      end else begin
        oc[i] <= next_oc[i];
      end
    end
  end

  // Top-level outputs
  assign CHAN_A_PIN    = pin_vec[0];
  assign CHAN_B_PIN    = pin_vec[1];
  assign COUNTER_VALUE = counter_value;
  assign COUNT_DOWN    = count_down;
  assign OVERFLOW_FLAG = overflow_flag;

  // Driver never enabled against an input direction
  pin_dir_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_02]
    (!DIR_A |-> !CHAN_A_PIN.oe) and (!DIR_B |-> !CHAN_B_PIN.oe))
    else $error("pin driver enabled while direction is input");

  // Override follows the output-mode fields outside PWM
  override_ab_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_01]
    (!is_fast && !is_pc) |-> (CHAN_A_PIN.override == (timer_waveform_control[7:6] != 2'b00))
                          && (CHAN_B_PIN.override == (timer_waveform_control[5:4] != 2'b00)))
    else $error("pin override does not follow output mode");

  // Non-PWM toggle changes the level
  toggle_nonpwm_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_03]
    (!is_fast && !is_pc && (timer_waveform_control[7:6] == 2'b01) && match[0])
    |=> (CHAN_A_PIN.out != $past(CHAN_A_PIN.out)))
    else $error("channel A did not toggle on match");

  // Non-inverting fast PWM sets at the wrap
  fast_bottom_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_04]
    (is_fast && (timer_waveform_control[7:6] == 2'b10) && wrap_evt) |=> CHAN_A_PIN.out)
    else $error("channel A not set at bottom");

  // Reserved control bits read back zero
  reserved_read_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_14]
    (setup && !PWRITE && (PADDR == tw_pkg::TW_ADDR_WAVE_CTRL)) ##1 access |-> (PRDATA[3:2] == 2'b00))
    else $error("reserved control bits read nonzero");

  // Fast PWM returns to zero after top
  fast_wrap_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_20]
    (is_fast && TIMER_TICK && at_top && !wr_count) |=> (counter_value == tw_pkg::TW_BOTTOM))
    else $error("fast PWM counter did not wrap at top");

  // Phase correct turns down after one tick at top
  pc_turn_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_21]
    (is_pc && TIMER_TICK && at_top && !count_down && !wr_count && (top != tw_pkg::TW_BOTTOM))
    |=> count_down && (counter_value == 8'($past(counter_value) - 8'h01)))
    else $error("phase correct counter did not reverse at top");

  // Normal mode overflow at max
  ovf_max_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_18]
    ((wave_mode_select == tw_pkg::TW_MODE_NORMAL) && TIMER_TICK && (counter_value == tw_pkg::TW_MAX))
    |=> overflow_flag)
    else $error("overflow flag not set at max");

  // Phase correct B sets on down-count match when set to 10
  pc_down_b_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N) // [RULE_12]
    (is_pc && (timer_waveform_control[5:4] == 2'b10) && match[1] && count_down && (cmp_act[1] != top))
    |=> CHAN_B_PIN.out)
    else $error("channel B not set on down-count match");

endmodule

`default_nettype wire

// ==== rtl/tw_pkg.sv ====
// Package for the 8-bit timer waveform control block.
// Holds register offsets, field positions, reset values and mode encodings.
// Assumes an APB slave with 12-bit byte addresses and 32-bit data.
package tw_pkg;

  // Register byte offsets
  localparam logic [11:0] TW_ADDR_WAVE_CTRL = 12'h024;
  localparam logic [11:0] TW_ADDR_MODE_CTRL = 12'h028;
  localparam logic [11:0] TW_ADDR_CMP_A     = 12'h02c;
  localparam logic [11:0] TW_ADDR_CMP_B     = 12'h030;
  localparam logic [11:0] TW_ADDR_COUNT     = 12'h034;
  localparam logic [11:0] TW_ADDR_STATUS    = 12'h038;

  // Field positions
  localparam int TW_CHA_MODE_LSB = 6;
  localparam int TW_CHB_MODE_LSB = 4;
  localparam int TW_MODE_HIGH_POS = 3;
  localparam int TW_OVF_POS      = 0;
  localparam int TW_DIR_POS      = 1;

  // Writable bits of the waveform control register
  localparam logic [7:0] TW_WAVE_CTRL_WMASK = 8'hf3;

  // Values after reset and counter limits
  localparam logic [7:0] TW_RESET_BYTE = 8'h00;
  localparam logic [7:0] TW_MAX        = 8'hff;
  localparam logic [7:0] TW_BOTTOM     = 8'h00;

  // Waveform modes
  typedef enum logic [2:0] {
    TW_MODE_NORMAL   = 3'b000,
    TW_MODE_PC_FF    = 3'b001,
    TW_MODE_CLR_MATCH = 3'b010,
    TW_MODE_FAST_FF  = 3'b011,
    TW_MODE_RSV4     = 3'b100,
    TW_MODE_PC_CMP   = 3'b101,
    TW_MODE_RSV6     = 3'b110,
    TW_MODE_FAST_CMP = 3'b111
  } tw_mode_type;

  // Per-channel output modes
  typedef enum logic [1:0] {
    TW_OUT_OFF    = 2'b00,
    TW_OUT_TOGGLE = 2'b01,
    TW_OUT_CLEAR  = 2'b10,
    TW_OUT_SET    = 2'b11
  } tw_out_mode_type;

  // Compare-output pin bundle
  typedef struct packed {
    logic out;
    logic oe;
    logic override;
  } tw_pin_type;

endpackage

// ==== testbench/tw_waveform_control_tb_top.sv ====
// Self-checking bench for the timer waveform control block.
// Assumes tw_pkg is compiled first; the bench drives APB, tick and direction.
`timescale 1ns/10ps
`default_nettype none
module tw_waveform_control_tb_top;
  logic              clk_sys;
  logic              arst_n;
  logic [11:0]       paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic [31:0]       prdata;
  logic              pslverr;
  logic              tick;
  logic              dir_a;
  logic              dir_b;
  tw_pkg::tw_pin_type pin_a;
  tw_pkg::tw_pin_type pin_b;
  logic [7:0]        counter_value;
  logic              count_down;
  logic              overflow_flag;
  logic [31:0]       rdata;
  logic              rerr;
  int                miscompares;
  int                num_checks;
  logic [1:0]        om [4] = '{2'd3, 2'd2, 2'd1, 2'd1};
  logic              oexp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tw_waveform_control DUT (
    .CLK_SYS       (clk_sys),
    .ARST_N        (arst_n),
    .PADDR         (paddr),
    .PSEL          (psel),
    .PENABLE       (penable),
    .PWRITE        (pwrite),
    .PWDATA        (pwdata),
    .PSTRB         (pstrb),
    .PREADY        (pready),
    .PRDATA        (prdata),
    .PSLVERR       (pslverr),
    .TIMER_TICK    (tick),
    .DIR_A         (dir_a),
    .DIR_B         (dir_b),
    .CHAN_A_PIN    (pin_a),
    .CHAN_B_PIN    (pin_b),
    .COUNTER_VALUE (counter_value),
    .COUNT_DOWN    (count_down),
    .OVERFLOW_FLAG (overflow_flag)
  );

  // Free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Final report and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compare a register word
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Compare a single pin or flag
  task automatic chkb(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(nm, exp, rdata);
  endtask

  // Single-cycle timer ticks, outputs settled on return
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      tick <= 1'b1;
      @(posedge clk_sys);
      tick <= 1'b0;
    end
    #1;
  endtask

  // Tick until the counter shows a value in a given direction
  task automatic run_to(input logic dn, input logic [7:0] v);
    int n;
    n = 0;
    while (!(count_down === dn && counter_value === v) && n < 600) begin
      step(1);
      n++;
    end
    if (n >= 600) begin
      miscompares++;
      summarize();
    end
  endtask

  // Main sequence
  initial begin
    miscompares = 0;
    num_checks  = 0;
    arst_n  = 1'b0;
    paddr   = 12'h0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
    tick    = 1'b0;
    dir_a   = 1'b1;
    dir_b   = 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset values, reserved bits, unmapped place
    rd("ctrl reset", tw_pkg::TW_ADDR_WAVE_CTRL, 32'h0);
    rd("status reset", tw_pkg::TW_ADDR_STATUS, 32'h0);
    wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'hff);
    rd("ctrl mask", tw_pkg::TW_ADDR_WAVE_CTRL, 32'hf3);
    apb(12'h040, 1'b0, 32'h0);
    chk("unmapped data", 32'h0, rdata);
    chkb("unmapped err", 1'b1, rerr);
    // Pin override and driver enable for every output mode
    for (int m = 0; m < 4; m++) begin
      wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'(m * 8'h50));
      chkb("a override", m != 0, pin_a.override);
      chkb("a enable", m != 0, pin_a.oe);
      chkb("b override", m != 0, pin_b.override);
      chkb("b enable", 1'b0, pin_b.oe);
    end
    @(posedge clk_sys);
    dir_b <= 1'b1;
    // Normal mode match actions: set, clear, toggle twice
    wr(tw_pkg::TW_ADDR_CMP_A, 32'h10);
    wr(tw_pkg::TW_ADDR_CMP_B, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'(om[i] * 8'h50));
      wr(tw_pkg::TW_ADDR_COUNT, 32'h0f);
      step(2);
      chkb("a out normal", oexp[i], pin_a.out);
      chkb("b out normal", oexp[i], pin_b.out);
    end
    wr(tw_pkg::TW_ADDR_COUNT, 32'hff);
    step(1);
    chkb("ovf normal", 1'b1, overflow_flag);
    rd("status ovf", tw_pkg::TW_ADDR_STATUS, 32'h1);
    wr(tw_pkg::TW_ADDR_STATUS, 32'h1);
    chkb("ovf cleared", 1'b0, overflow_flag);
    // Fast PWM mode 3: A non-inverting, B inverting
    wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'hb3);
    wr(tw_pkg::TW_ADDR_COUNT, 32'hff);
    step(1);
    chk("fast wrap", 32'h0, 32'(counter_value));
    chkb("a at bottom", 1'b1, pin_a.out);
    chkb("b at bottom", 1'b0, pin_b.out);
    chkb("ovf fast", 1'b1, overflow_flag);
    step(17);
    chkb("a fast match", 1'b0, pin_a.out);
    chkb("b fast match", 1'b1, pin_b.out);
    wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'h53);
    chkb("a 01 low", 1'b0, pin_a.override);
    chkb("b 01 fast", 1'b0, pin_b.override);
    // Fast PWM mode 7: top from compare A, A toggles
    wr(tw_pkg::TW_ADDR_STATUS, 32'h1);
    wr(tw_pkg::TW_ADDR_MODE_CTRL, 32'h08);
    rd("mode ctrl", tw_pkg::TW_ADDR_MODE_CTRL, 32'h08);
    chkb("a 01 high", 1'b1, pin_a.override);
    chkb("b 01 high", 1'b0, pin_b.override);
    wr(tw_pkg::TW_ADDR_COUNT, 32'h0e);
    step(3);
    chk("top wrap", 32'h0, 32'(counter_value));
    chkb("a toggle", 1'b1, pin_a.out);
    chkb("ovf top", 1'b1, overflow_flag);
    // Compare equal to top: match ignored, action at the wrap
    wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'hf3);
    wr(tw_pkg::TW_ADDR_COUNT, 32'h0e);
    step(3);
    chkb("a top inverting", 1'b0, pin_a.out);
    chkb("b top inverting", 1'b0, pin_b.out);
    wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'ha3);
    wr(tw_pkg::TW_ADDR_COUNT, 32'h0e);
    step(3);
    chkb("a top noninverting", 1'b1, pin_a.out);
    chkb("b top noninverting", 1'b1, pin_b.out);
    // Phase correct mode 1, compare A moved while up-counting
    wr(tw_pkg::TW_ADDR_STATUS, 32'h1);
    wr(tw_pkg::TW_ADDR_MODE_CTRL, 32'h0);
    wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'ha1);
    wr(tw_pkg::TW_ADDR_COUNT, 32'h0f);
    step(2);
    chkb("a up match", 1'b0, pin_a.out);
    chkb("b up match", 1'b0, pin_b.out);
    chkb("b enable pc", 1'b1, pin_b.oe);
    @(posedge clk_sys);
    dir_a <= 1'b0;
    #1;
    chkb("a enable input", 1'b0, pin_a.oe);
    chkb("a override input", 1'b1, pin_a.override);
    @(posedge clk_sys);
    dir_a <= 1'b1;
    wr(tw_pkg::TW_ADDR_CMP_A, 32'h20);
    run_to(1'b0, 8'hfe);
    step(1);
    chk("at top", 32'hff, 32'(counter_value));
    step(1);
    chk("after top", 32'hfe, 32'(counter_value));
    chkb("dir down", 1'b1, count_down);
    run_to(1'b1, 8'h20);
    step(1);
    chkb("a down match", 1'b1, pin_a.out);
    chkb("b before match", 1'b0, pin_b.out);
    run_to(1'b1, 8'h10);
    step(1);
    chkb("b down match", 1'b1, pin_b.out);
    chkb("ovf not max", 1'b0, overflow_flag);
    run_to(1'b1, 8'h00);
    step(1);
    chkb("ovf bottom", 1'b1, overflow_flag);
    // Clear-on-match mode 2: top from compare A, A toggles
    wr(tw_pkg::TW_ADDR_STATUS, 32'h1);
    wr(tw_pkg::TW_ADDR_WAVE_CTRL, 32'h42);
    wr(tw_pkg::TW_ADDR_COUNT, 32'h1f);
    step(2);
    chk("match top wrap", 32'h0, 32'(counter_value));
    chkb("a match toggle", 1'b0, pin_a.out);
    chkb("ovf not top", 1'b0, overflow_flag);
    summarize();
  end
endmodule
`default_nettype wire
